// *** design/ivlp_pkg.sv ***
/*
  Constants for the interrupt vectoring and low-power control block.
  Assumes one system clock; vector addresses are byte addresses of words.
*/
// Function
// (RULE_01) Vectors live at top of memory, 16-bit handlers
// (RULE_02) Erased reset vector sends device to deepest sleep
// (RULE_03) All reset causes use reset vector, top priority
// (RULE_04) Fetch from register or unused region resets
// (RULE_05) NMI, oscillator fault, access violation share vector
// (RULE_06) Individual enables gate level-30 sources, global not
// (RULE_07) Seven-channel timer: channel 0 apart, others shared
// (RULE_08) Comparator, interval watchdog, timer3 channel 0 dedicated
// (RULE_09) Timer3 channels 1, 2 and overflow share vector
// (RULE_10) First serial pair: shared receive and transmit vectors
// (RULE_11) I2C mode: status flags replace receive source
// (RULE_12) I2C mode: receive and transmit both on transmit
// (RULE_13) Converter 21, 20 unused, port two 19, one 18
// (RULE_14) Second serial pair: receive 17, transmit 16
// (RULE_15) Priorities 15 to 0 carry no interrupt
// (RULE_16) Key pattern in lowest word disables boot loader
// (RULE_17) Zero key word blocks erase on bad password
// (RULE_18) Interrupt wakes device, return restores sleep mode
// (RULE_19) Active runs all; mode zero stops core, main
// (RULE_20) Mode one also drops unused oscillator dc generator
// (RULE_21) Mode two stops submain, keeps generator and auxiliary
// (RULE_22) Mode three drops generator; four stops everything
// (RULE_23) Highest pending enabled priority is delivered first
package ivlp_pkg;
  localparam logic [15:0] VEC_TOP        = 16'hffff;
  localparam logic [15:0] VEC_BASE       = 16'hffc0;
  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [15:0] VEC_ERASED     = 16'hffff;
  localparam logic [15:0] VEC_LOWEST     = 16'hffde;
  localparam logic [15:0] KEY_BSL_OFF    = 16'haa55;
  localparam logic [15:0] KEY_NO_ERASE   = 16'h0000;
  localparam logic [15:0] REG_LO         = 16'h0000;
  localparam logic [15:0] REG_HI         = 16'h01ff;
  localparam logic [4:0]  PRI_RESET      = 5'h1f;
  localparam logic [4:0]  PRI_NMI        = 5'h1e;
  localparam logic [4:0]  PRI_T7_CH0     = 5'h1d;
  localparam logic [4:0]  PRI_T7_REST    = 5'h1c;
  localparam logic [4:0]  PRI_COMP       = 5'h1b;
  localparam logic [4:0]  PRI_WDT        = 5'h1a;
  localparam logic [4:0]  PRI_T3_CH0     = 5'h19;
  localparam logic [4:0]  PRI_T3_REST    = 5'h18;
  localparam logic [4:0]  PRI_SA_RX      = 5'h17;
  localparam logic [4:0]  PRI_SA_TX      = 5'h16;
  localparam logic [4:0]  PRI_ADC        = 5'h15;
  localparam logic [4:0]  PRI_UNUSED     = 5'h14;
  localparam logic [4:0]  PRI_P2         = 5'h13;
  localparam logic [4:0]  PRI_P1         = 5'h12;
  localparam logic [4:0]  PRI_SB_RX      = 5'h11;
  localparam logic [4:0]  PRI_SB_TX      = 5'h10;
  localparam int          PRI_USED_LO    = 16;
  typedef enum logic [2:0] {
    IVLP_ACTIVE, IVLP_SLEEP_MODE_ZERO, IVLP_LPM1, IVLP_LPM2, IVLP_LPM3, IVLP_DEEPEST_SLEEP_MODE
  } ivlp_mode_t;
  typedef enum logic [1:0] {
    IVLP_BOOT, IVLP_RUN, IVLP_ISR
  } ivlp_state_t;
  function automatic logic [15:0] ivlp_vec_addr(input logic [4:0] pri);
    ivlp_vec_addr = VEC_BASE + {10'h000, pri, 1'b0};
  endfunction
endpackage

// *** design/ivlp_vec_mem.sv ***
/*
  Vector table store: 32 words at the top of memory, registered read.
  Assumes the loader writes it before the core leaves reset.
*/
`timescale 1ns/1ps
module ivlp_vec_mem
  import ivlp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        clk_en,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic [4:0]  rd_idx,
  output logic [15:0]      rd_data
);
  logic [15:0] mem [0:31];

  // Handler words; index equals priority
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_idx] <= wr_data; // RULE_01
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// *** design/ivlp_ctrl.sv ***
/*
  Interrupt vector resolution, reset causes and low-power clock control.
  Assumes peripheral flags are levels held until their handler clears them,
  and the core pulses irq_ret on return from interrupt.
*/
`timescale 1ns/1ps
module ivlp_ctrl
  import ivlp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        vec_wr_en,
  input  wire logic [4:0]  vec_wr_idx,
  input  wire logic [15:0] vec_wr_data,
  input  wire logic        boot_done,
  input  wire logic        power_up_flag,
  input  wire logic        external_reset_flag,
  input  wire logic        watchdog_flag,
  input  wire logic        flash_key_violation_flag,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        unused_region,
  input  wire logic        pin_nmi_flag,
  input  wire logic        pin_nmi_en,
  input  wire logic        osc_fault_flag,
  input  wire logic        osc_fault_en,
  input  wire logic        flash_access_violation_flag,
  input  wire logic        flash_access_en,
  input  wire logic        global_ie,
  input  wire logic [6:0]  compare_channel_flag,
  input  wire logic [6:0]  t7_ie,
  input  wire logic        timer7_overflow_flag,
  input  wire logic        t7_ovf_ie,
  input  wire logic        comparator_flag,
  input  wire logic        comparator_ie,
  input  wire logic        wdt_interval_mode,
  input  wire logic        wdt_ie,
  input  wire logic [2:0]  t3_flags,
  input  wire logic [2:0]  t3_ie,
  input  wire logic        timer3_overflow_flag,
  input  wire logic        t3_ovf_ie,
  input  wire logic        serial_a_first_rx_flag,
  input  wire logic        serial_a_first_tx_flag,
  input  wire logic        serial_b_first_rx_flag,
  input  wire logic        serial_b_first_tx_flag,
  input  wire logic        serial_b_first_i2c,
  input  wire logic        arbitration_lost_flag,
  input  wire logic        nack_received_flag,
  input  wire logic        start_detected_flag,
  input  wire logic        stop_detected_flag,
  input  wire logic [3:0]  serial_first_ie,
  input  wire logic        converter_flag,
  input  wire logic        converter_ie,
  input  wire logic [7:0]  port_two_pin_flags,
  input  wire logic [7:0]  port_two_ie,
  input  wire logic [7:0]  port_one_pin_flags,
  input  wire logic [7:0]  port_one_ie,
  input  wire logic        serial_a_second_rx_flag,
  input  wire logic        serial_b_second_rx_flag,
  input  wire logic        serial_a_second_tx_flag,
  input  wire logic        serial_b_second_tx_flag,
  input  wire logic [3:0]  serial_second_ie,
  input  wire logic        sleep_req,
  input  wire ivlp_mode_t  sleep_mode,
  input  wire logic        irq_ret,
  input  wire logic        digital_osc_used,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic [4:0]       irq_level,
  output logic             core_reset,
  output ivlp_mode_t       mode,
  output logic             core_clk_en,
  output logic             main_clk_en,
  output logic             submain_clock_en,
  output logic             aux_clk_en,
  output logic             dc_gen_en,
  output logic             crystal_en,
  output logic             bootloader_off,
  output logic             bad_pw_no_erase
);
  logic [31:0]  pend;
  logic [4:0]   win;
  logic         any;
  logic [4:0]   rd_idx;
  logic [15:0]  rd_data;
  logic [1:0]   boot_step_r;
  logic [4:0]   rd_tag_r;
  ivlp_state_t  state_r;
  ivlp_mode_t   saved_r;
  logic         bad_fetch;

  ivlp_vec_mem u_mem (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .wr_en   (vec_wr_en),
    .wr_idx  (vec_wr_idx),
    .wr_data (vec_wr_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  assign bad_fetch = fetch_valid && (unused_region ||
                     (fetch_addr >= REG_LO && fetch_addr <= REG_HI)); // RULE_04

  // Pending, enabled requests by priority
  always_comb begin
    pend = '0;
    pend[PRI_RESET]   = power_up_flag | external_reset_flag | watchdog_flag & ~wdt_interval_mode
                      | flash_key_violation_flag | bad_fetch; // RULE_03
    pend[PRI_NMI]     = pin_nmi_flag & pin_nmi_en | osc_fault_flag & osc_fault_en
                      | flash_access_violation_flag & flash_access_en; // RULE_05 RULE_06
    pend[PRI_T7_CH0]  = global_ie & compare_channel_flag[0] & t7_ie[0]; // RULE_07
    pend[PRI_T7_REST] = global_ie & (|(compare_channel_flag[6:1] & t7_ie[6:1])
                      | timer7_overflow_flag & t7_ovf_ie); // RULE_07
    pend[PRI_COMP]    = global_ie & comparator_flag & comparator_ie; // RULE_08
    pend[PRI_WDT]     = global_ie & wdt_interval_mode & watchdog_flag & wdt_ie; // RULE_08
    pend[PRI_T3_CH0]  = global_ie & t3_flags[0] & t3_ie[0]; // RULE_08
    pend[PRI_T3_REST] = global_ie & (|(t3_flags[2:1] & t3_ie[2:1])
                      | timer3_overflow_flag & t3_ovf_ie); // RULE_09
    pend[PRI_SA_RX]   = global_ie & (serial_a_first_rx_flag & serial_first_ie[0]
                      | (serial_b_first_i2c
                         ? (arbitration_lost_flag | nack_received_flag
                            | start_detected_flag | stop_detected_flag) // RULE_11
                         : serial_b_first_rx_flag) & serial_first_ie[2]); // RULE_10
    pend[PRI_SA_TX]   = global_ie & (serial_a_first_tx_flag & serial_first_ie[1]
                      | serial_b_first_tx_flag & serial_first_ie[3]
                      | serial_b_first_i2c & serial_b_first_rx_flag
                        & serial_first_ie[2]); // RULE_10 RULE_12
    pend[PRI_ADC]     = global_ie & converter_flag & converter_ie; // RULE_13
    pend[PRI_P2]      = global_ie & |(port_two_pin_flags & port_two_ie); // RULE_13
    pend[PRI_P1]      = global_ie & |(port_one_pin_flags & port_one_ie); // RULE_13
    pend[PRI_SB_RX]   = global_ie & (serial_a_second_rx_flag & serial_second_ie[0]
                      | serial_b_second_rx_flag & serial_second_ie[2]); // RULE_14
    pend[PRI_SB_TX]   = global_ie & (serial_a_second_tx_flag & serial_second_ie[1]
                      | serial_b_second_tx_flag & serial_second_ie[3]); // RULE_14
  end

  // Highest set index wins; levels below 16 never set
  always_comb begin
    win = PRI_RESET;
    any = 1'b0;
    for (int i = PRI_USED_LO; i < 32; i++) begin
      if (pend[i]) begin
        win = 5'(i); // RULE_23 RULE_15
        any = 1'b1;
      end
    end
  end

  // Boot reads reset vector then key word; run reads winner
  always_comb begin
    if (state_r == IVLP_BOOT) begin
      rd_idx = (boot_step_r != 2'h0) ? 5'h0f : PRI_RESET; // RULE_16
    end else begin
      rd_idx = win;
    end
  end

  // Index of the word now held in the registered read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_tag_r <= PRI_RESET;
    end else if (clk_en) begin
      rd_tag_r <= rd_idx;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r    <= IVLP_BOOT;
      boot_step_r <= 2'h0;
      saved_r    <= IVLP_ACTIVE;
      mode       <= IVLP_ACTIVE;
      irq_req    <= 1'b0;
      irq_vector <= 16'h0000;
      irq_level  <= 5'h00;
      core_reset <= 1'b1;
      bootloader_off  <= 1'b0;
      bad_pw_no_erase <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        IVLP_BOOT: begin
          if (boot_done) begin
            if (boot_step_r == 2'h0) begin
              boot_step_r <= 2'h1;
              irq_vector  <= rd_data; // RULE_01
              irq_level   <= PRI_RESET;
              if (rd_data == VEC_ERASED) begin
                mode <= IVLP_DEEPEST_SLEEP_MODE; // RULE_02
              end else begin
                core_reset <= 1'b0;
              end
            end else if (boot_step_r == 2'h1) begin
              // Middle step lets the key word read settle
              boot_step_r <= 2'h2;
            end else begin
              bootloader_off  <= (rd_data == KEY_BSL_OFF); // RULE_16
              bad_pw_no_erase <= (rd_data == KEY_NO_ERASE); // RULE_17
              state_r         <= IVLP_RUN;
            end
          end
        end
        IVLP_RUN: begin
          irq_req <= 1'b0;
          if (any && win == PRI_RESET) begin
            core_reset <= 1'b1; // RULE_03 RULE_04
            mode       <= IVLP_ACTIVE;
            boot_step_r <= 2'h0;
            state_r    <= IVLP_BOOT;
          end else if (any && !core_reset) begin
            // Fire only once the read holds the winner's word
            if (rd_tag_r == win) begin
              irq_req    <= 1'b1;
              irq_vector <= rd_data; // RULE_23
              irq_level  <= win;
              saved_r    <= mode;
              mode       <= IVLP_ACTIVE; // RULE_18
              state_r    <= IVLP_ISR;
            end
          end else if (sleep_req && !core_reset) begin
            mode <= sleep_mode;
          end
        end
        IVLP_ISR: begin
          irq_req <= 1'b0;
          if (irq_ret) begin
            mode    <= saved_r; // RULE_18
            state_r <= IVLP_RUN;
          end
        end
        default: state_r <= IVLP_BOOT;
      endcase
    end
  end

  // Clock gating per mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_clk_en      <= 1'b1;
      main_clk_en      <= 1'b1;
      submain_clock_en <= 1'b1;
      aux_clk_en       <= 1'b1;
      dc_gen_en        <= 1'b1;
      crystal_en       <= 1'b1;
    end else if (clk_en) begin
      core_clk_en      <= (mode == IVLP_ACTIVE); // RULE_19
      main_clk_en      <= (mode == IVLP_ACTIVE); // RULE_19
      submain_clock_en <= (mode == IVLP_ACTIVE || mode == IVLP_SLEEP_MODE_ZERO
                           || mode == IVLP_LPM1); // RULE_21
      aux_clk_en       <= (mode != IVLP_DEEPEST_SLEEP_MODE); // RULE_22
      dc_gen_en        <= (mode == IVLP_ACTIVE || mode == IVLP_SLEEP_MODE_ZERO || mode == IVLP_LPM2
                           || (mode == IVLP_LPM1 && digital_osc_used)); // RULE_20 RULE_22
      crystal_en       <= (mode != IVLP_DEEPEST_SLEEP_MODE); // RULE_22
    end
  end

  a_deepest_sleep_mode_aux_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE_22
    clk_en && mode == IVLP_DEEPEST_SLEEP_MODE |=> !aux_clk_en && !crystal_en)
    else $error("aux clock runs in deepest mode");
  a_sleep_mode_zero_clocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_19
    clk_en && mode == IVLP_SLEEP_MODE_ZERO |=> !main_clk_en && submain_clock_en && aux_clk_en)
    else $error("mode zero gating wrong");
  a_lpm2_clocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_21
    clk_en && mode == IVLP_LPM2 |=> !submain_clock_en && dc_gen_en)
    else $error("mode two gating wrong");
  a_lpm3_dcgen: assert property (@(posedge sys_clk) disable iff (rst) // RULE_22
    clk_en && mode == IVLP_LPM3 |=> !dc_gen_en && aux_clk_en)
    else $error("mode three gating wrong");
  a_lpm1_dcgen: assert property (@(posedge sys_clk) disable iff (rst) // RULE_20
    clk_en && mode == IVLP_LPM1 && !digital_osc_used |=> !dc_gen_en)
    else $error("mode one generator on");
  a_active_clocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_19
    clk_en && mode == IVLP_ACTIVE |=> core_clk_en && main_clk_en && submain_clock_en
    && aux_clk_en && dc_gen_en && crystal_en)
    else $error("clock stopped in active mode");
  a_wake_active: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
    irq_req |-> mode == IVLP_ACTIVE)
    else $error("interrupt left device asleep");
  a_return_mode: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
    clk_en && state_r == IVLP_ISR && irq_ret |=> mode == $past(saved_r))
    else $error("sleep mode not restored");
  a_level_range: assert property (@(posedge sys_clk) disable iff (rst) // RULE_15
    irq_req |-> irq_level >= 5'h10 && irq_level != PRI_UNUSED && irq_level != PRI_RESET)
    else $error("bad interrupt level");
  a_nmi_no_gie: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    clk_en && state_r == IVLP_RUN && !core_reset && !pend[PRI_RESET] && !global_ie
    && pin_nmi_flag && pin_nmi_en && rd_tag_r == PRI_NMI |=> irq_req && irq_level == PRI_NMI)
    else $error("nmi source blocked");
  a_single_pulse: assert property (@(posedge sys_clk) disable iff (rst) // RULE_23
    clk_en && irq_req |=> !irq_req)
    else $error("request not held off");
  a_bad_fetch: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    clk_en && state_r == IVLP_RUN && bad_fetch |=> core_reset)
    else $error("bad fetch without reset");
  a_reset_entry: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    clk_en && state_r == IVLP_RUN && pend[PRI_RESET] |=> core_reset && state_r == IVLP_BOOT)
    else $error("reset cause ignored");
  a_erased_sleep: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    clk_en && state_r == IVLP_BOOT && boot_done && boot_step_r == 2'h0
    && rd_data == VEC_ERASED |=> mode == IVLP_DEEPEST_SLEEP_MODE && core_reset)
    else $error("erased reset vector runs code");
  a_key_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
    clk_en && state_r == IVLP_BOOT && boot_done && boot_step_r == 2'h2
    |=> bootloader_off == ($past(rd_data) == KEY_BSL_OFF))
    else $error("boot loader key not applied");
  a_key_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE_17
    clk_en && state_r == IVLP_BOOT && boot_done && boot_step_r == 2'h2
    |=> bad_pw_no_erase == ($past(rd_data) == KEY_NO_ERASE))
    else $error("erase guard key not applied");
endmodule

// *** verif/ivlp_core_model.sv ***
/*
  Behavioural model of the processor core's handler side.
  Assumes irq_req is a one-cycle pulse; answers with irq_ret after ret_wait cycles.
*/
`timescale 1ns/1ps
module ivlp_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic [3:0] ret_wait,
  output logic            irq_ret
);
  int cnt_r = 0;

  initial irq_ret = 1'b0;

  // Handler runs ret_wait cycles, then returns
  always @(negedge sys_clk) begin
    if (rst) begin
      irq_ret <= 1'b0;
      cnt_r   <= 0;
    end else if (irq_req === 1'b1) begin
      irq_ret <= 1'b0;
      cnt_r   <= int'(ret_wait);
    end else begin
      irq_ret <= (cnt_r == 1);
      if (cnt_r > 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule

// *** verif/testbench.sv ***
/*
  Self-checking bench for the interrupt vectoring and low-power controller.
  Assumes flags are levels cleared by the bench once their request is seen.
*/
`timescale 1ns/1ps
module testbench;
  import ivlp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        vec_wr_en = 1'b0;
  logic [4:0]  vec_wr_idx = 5'h00;
  logic [15:0] vec_wr_data = 16'h0000;
  logic        boot_done = 1'b0;
  logic [3:0]  rsrc = 4'h0;
  logic        fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'h0200;
  logic [45:0] fl = '0;
  logic [43:0] en = '0;
  logic        wdt_interval_mode = 1'b0;
  logic        sleep_req = 1'b0;
  ivlp_mode_t  sleep_mode = IVLP_ACTIVE;
  logic        digital_osc_used = 1'b0;
  logic [3:0]  ret_wait = 4'h2;
  logic        irq_ret, irq_req, core_reset, bootloader_off, bad_pw_no_erase;
  logic [15:0] irq_vector;
  logic [4:0]  irq_level;
  ivlp_mode_t  mode;
  logic [5:0]  clks;
  logic [15:0] vw [32];
  logic [31:0] seed = 32'h380bf0b8;
  logic [63:0] r;
  int          n_mismatch = 0;
  int          checks = 0;
  int          lv;

  always #4 sys_clk = ~sys_clk;

  ivlp_core_model u_ivlp_core_model (.sys_clk, .rst, .irq_req, .ret_wait, .irq_ret);
  ivlp_ctrl u_ivlp_ctrl (
    .sys_clk, .rst, .clk_en, .vec_wr_en, .vec_wr_idx, .vec_wr_data, .boot_done,
    .power_up_flag(rsrc[3]), .external_reset_flag(rsrc[2]), .watchdog_flag(fl[0]),
    .flash_key_violation_flag(rsrc[1]), .fetch_valid, .fetch_addr, .unused_region(rsrc[0]),
    .pin_nmi_flag(fl[31]), .pin_nmi_en(en[31]), .osc_fault_flag(fl[32]), .osc_fault_en(en[32]),
    .flash_access_violation_flag(fl[33]), .flash_access_en(en[33]), .global_ie(en[42]),
    .compare_channel_flag(fl[25:19]), .t7_ie(en[25:19]), .timer7_overflow_flag(fl[26]),
    .t7_ovf_ie(en[26]), .comparator_flag(fl[1]), .comparator_ie(en[1]), .wdt_interval_mode,
    .wdt_ie(en[0]), .t3_flags(fl[29:27]), .t3_ie(en[29:27]), .timer3_overflow_flag(fl[30]),
    .t3_ovf_ie(en[30]), .serial_a_first_rx_flag(fl[34]), .serial_a_first_tx_flag(fl[35]),
    .serial_b_first_rx_flag(fl[36]), .serial_b_first_tx_flag(fl[37]),
    .serial_b_first_i2c(en[43]), .arbitration_lost_flag(fl[38]), .nack_received_flag(fl[39]),
    .start_detected_flag(fl[40]), .stop_detected_flag(fl[41]), .serial_first_ie(en[37:34]),
    .converter_flag(fl[18]), .converter_ie(en[18]), .port_two_pin_flags(fl[17:10]),
    .port_two_ie(en[17:10]), .port_one_pin_flags(fl[9:2]), .port_one_ie(en[9:2]),
    .serial_a_second_rx_flag(fl[42]), .serial_b_second_rx_flag(fl[44]),
    .serial_a_second_tx_flag(fl[43]), .serial_b_second_tx_flag(fl[45]),
    .serial_second_ie(en[41:38]), .sleep_req, .sleep_mode, .irq_ret, .digital_osc_used,
    .irq_req, .irq_vector, .irq_level, .core_reset, .mode, .core_clk_en(clks[5]),
    .main_clk_en(clks[4]), .submain_clock_en(clks[3]), .aux_clk_en(clks[2]),
    .dc_gen_en(clks[1]), .crystal_en(clks[0]), .bootloader_off, .bad_pw_no_erase
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Highest enabled pending level, -1 when none
  function automatic int exp_lvl();
    logic [31:0] p;
    logic [45:0] m;
    m = fl & {en[41:38], {4{en[36]}}, en[37:0]};
    p = '0;
    p[30] = |m[33:31];
    p[29] = m[19];
    p[28] = |m[26:20];
    p[27] = m[1];
    p[26] = m[0] & wdt_interval_mode;
    p[25] = m[27];
    p[24] = |m[30:28];
    p[23] = m[34] | (en[43] ? |m[41:38] : m[36]);
    p[22] = m[35] | m[37] | (en[43] & m[36]);
    p[21] = m[18];
    p[19] = |m[17:10];
    p[18] = |m[9:2];
    p[17] = m[42] | m[44];
    p[16] = m[43] | m[45];
    p[29:16] &= {14{en[42]}};
    exp_lvl = -1;
    for (int i = 16; i < 31; i++) begin
      if (p[i]) exp_lvl = i;
    end
  endfunction

  // Clock enables {core, main, submain, aux, dc, crystal} per mode
  function automatic logic [5:0] exp_clk(input int m);
    case (m)
      1: exp_clk = 6'h0f;
      2: exp_clk = {4'h3, digital_osc_used, 1'b1};
      3: exp_clk = 6'h07;
      4: exp_clk = 6'h05;
      5: exp_clk = 6'h00;
      default: exp_clk = 6'h3f;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic reboot();
    boot_done = 1'b1;
    cyc(3);
    boot_done = 1'b0;
    if (vw[31] !== 16'hffff) begin
      chk("boot level", 16'h001f, 16'(irq_level));
      chk("boot vector", vw[31], irq_vector);
      chk("boot core reset", 16'h0000, 16'(core_reset));
    end
  endtask

  task automatic boot(input logic [15:0] rv, input logic [15:0] key);
    rst = 1'b1;
    cyc(8);
    chk("reset clocks", 16'h003f, 16'(clks));
    chk("reset core", 16'h0001, 16'(core_reset));
    rst = 1'b0;
    vw[31] = rv;
    vw[15] = key;
    for (int i = 0; i < 32; i++) begin
      vec_wr_en = 1'b1;
      vec_wr_idx = 5'(i);
      vec_wr_data = vw[i];
      cyc(1);
    end
    vec_wr_en = 1'b0;
    cyc(1);
    reboot();
    if (rv === 16'hffff) begin
      chk("erased mode", 16'(IVLP_DEEPEST_SLEEP_MODE), 16'(mode));
      chk("erased core", 16'h0001, 16'(core_reset));
      chk("erased clocks", 16'h0000, 16'(clks));
    end else begin
      chk("key off", 16'(key === 16'haa55), 16'(bootloader_off));
      chk("key zero", 16'(key === 16'h0000), 16'(bad_pw_no_erase));
    end
  endtask

  task automatic take(input int l);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 12) begin
      cyc(1);
      k++;
    end
    chk("request", 16'(l >= 0), 16'(irq_req));
    if (l >= 0) begin
      chk("level", 16'(l), 16'(irq_level));
      chk("vector", vw[l], irq_vector);
      chk("handler mode", 16'(IVLP_ACTIVE), 16'(mode));
    end
  endtask

  task automatic wait_ret();
    int k;
    k = 0;
    cyc(1);
    while (irq_ret !== 1'b1 && k < 30) begin
      chk("held off", 16'h0000, 16'(irq_req));
      cyc(1);
      k++;
    end
    chk("return", 16'h0001, 16'(irq_ret));
    cyc(1);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) vw[i] = 16'(rnd());
    boot(16'hffff, 16'h0000);
    boot(vw[30] & 16'hfffe, 16'haa55);
    boot(vw[29] & 16'hfffe, 16'h0000);
    boot(vw[28] & 16'hfffe, 16'h55aa);
    en = '1;
    fetch_valid = 1'b1;
    for (int s = 0; s < 7; s++) begin
      cyc(3);
      chk("no reset", 16'h0000, 16'(core_reset));
      rsrc = 4'h1 << s;
      if (s == 4) fetch_addr = 16'h01ff;
      if (s == 5) fetch_addr = vw[s] & 16'h01ff;
      if (s == 6) fl = 46'h1;
      cyc(2);
      chk("reset cause", 16'h0001, 16'(core_reset));
      rsrc = 4'h0;
      fl = '0;
      fetch_addr = 16'h0200;
      reboot();
    end
    wdt_interval_mode = 1'b1;
    ret_wait = 4'h9;
    clk_en = 1'b0;
    fl = 46'h3;
    cyc(4);
    chk("frozen", 16'h0000, 16'(irq_req));
    clk_en = 1'b1;
    take(27);
    fl = 46'h1;
    wait_ret();
    take(26);
    fl = '0;
    wait_ret();
    for (int p = 0; p < 2; p++) begin
      digital_osc_used = p[0];
      for (int m = 1; m < 7; m++) begin
        sleep_mode = ivlp_mode_t'(m % 6);
        sleep_req = 1'b1;
        cyc(1);
        sleep_req = 1'b0;
        cyc(2);
        chk("sleep mode", 16'(m % 6), 16'(mode));
        chk("sleep clocks", 16'(exp_clk(m % 6)), 16'(clks));
        fl = 46'h2;
        take(27);
        fl = '0;
        wait_ret();
        chk("restored", 16'(m % 6), 16'(mode));
      end
    end
    for (int t = 0; t < 80; t++) begin
      r = {rnd(), rnd()};
      en = r[43:0];
      ret_wait = r[63:60] | 4'h2;
      r = {rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()};
      fl = r[45:0];
      lv = exp_lvl();
      take(lv);
      fl = '0;
      if (lv >= 0) wait_ret();
    end
    results();
  end

  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
